/* include/mps_pkg.sv */
// Purpose: Shared constants and types for the module power and sleep control link
// Assumes: 125 MHz ref_clk, times held in microseconds
// Notes:   Long counts are also module parameters so a bench can shorten them
package mps_pkg;
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned PON_MIN_US       = 25000;
	localparam int unsigned RAIL_MAX_US      = 25000;
	localparam int unsigned RST_PULSE_US     = 10000;
	localparam int unsigned SLEEP_DELAY_US   = 1000;
	// Times convert to cycles by plain multiplication, with no rounding
	localparam int unsigned PON_MIN_CYC      = PON_MIN_US * CLK_MHZ;
	localparam int unsigned RAIL_MAX_CYC     = RAIL_MAX_US * CLK_MHZ;
	localparam int unsigned RST_PULSE_CYC    = RST_PULSE_US * CLK_MHZ;
	localparam int unsigned SLEEP_DELAY_CYC  = SLEEP_DELAY_US * CLK_MHZ;
	localparam int unsigned CNT_W            = 24;
	localparam logic [7:0]  WAKE_BYTE        = 8'h00;
	localparam logic [1:0]  SLEEP_CFG_RESET  = 2'h2;

	typedef enum logic [1:0] {
		SLP_DTR   = 2'h0,
		SLP_IDLE  = 2'h1,
		SLP_NEVER = 2'h2
	} mps_sleep_cfg_type;

	typedef enum {
		ST_OFF,
		ST_ON,
		ST_SLEEP
	} mps_state_type;
endpackage

/* include/mps_if.sv */
// Purpose: Control pins between host and module
// Assumes: Open-drain power-on request, pulled up when nobody drives it
// Notes:   Commands travel as one-cycle strobes in place of a serial stream
`timescale 1ns/1ps
interface mps_if;
	logic       power_on_request_n_oe;
	logic       power_on_request_n;
	logic       reset_in_n;
	logic       dtr_n;
	logic       rx_valid;
	logic [7:0] rx_byte;
	logic       off_cmd;
	logic       sleep_cmd;
	logic [1:0] sleep_cmd_arg;
	logic       io_rail_indicator;
	logic       asleep;

	// Wired level of the pulled-up request pin
	assign power_on_request_n = ~power_on_request_n_oe;

	modport dev (
		input  power_on_request_n, reset_in_n, dtr_n, rx_valid, rx_byte,
		input  off_cmd, sleep_cmd, sleep_cmd_arg,
		output io_rail_indicator, asleep
	);
	modport host (
		output power_on_request_n_oe, reset_in_n, dtr_n, rx_valid, rx_byte,
		output off_cmd, sleep_cmd, sleep_cmd_arg,
		input  power_on_request_n, io_rail_indicator, asleep
	);
endinterface

/* src/mps_device.sv */
// Purpose: Module end: power-up, switch-off, emergency off and sleep control
// Assumes: All link inputs synchronous to ref_clk
// Notes:   Off state also clears the working state, standing in for CPU and RAM reset
`timescale 1ns/1ps
module mps_device #(
	parameter int unsigned PON_CYC   = mps_pkg::PON_MIN_CYC,
	parameter int unsigned RST_CYC   = mps_pkg::RST_PULSE_CYC,
	parameter int unsigned SLEEP_CYC = mps_pkg::SLEEP_DELAY_CYC
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	mps_if.dev        link,
	input  wire logic tasks_busy,
	output logic      powered,
	output logic [1:0] sleep_cfg
);
	import mps_pkg::*;

	// Power state and its next value
	mps_state_type            state_q, state_d;

	// Low-time counters for the two control pins
	logic [CNT_W-1:0]         pon_cnt_q, pon_cnt_d;
	logic [CNT_W-1:0]         rst_cnt_q, rst_cnt_d;

	// Quiet time ahead of sleep entry
	logic [CNT_W-1:0]         idle_cnt_q, idle_cnt_d;

	// Sleep setting and registered outputs
	logic [1:0]               cfg_q, cfg_d;
	logic                     rail_q, asleep_q, powered_q;

	// Counter step that sticks at full scale, so a long hold never wraps
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
		return (c == '1) ? c : c + 1'b1;
	endfunction

	// Count reached test shared by all three counters
	function automatic logic reached(
		input logic [CNT_W-1:0] c,
		input int unsigned      n
	);
		return c >= CNT_W'(n - 1);
	endfunction

	// Sleep setting decode
	wire cfg_dtr     = (cfg_q == SLP_DTR);
	wire cfg_idle    = (cfg_q == SLP_IDLE);
	wire cfg_never   = (cfg_q == SLP_NEVER);

	// Pin levels in active-high form
	wire pon_low     = ~link.power_on_request_n;
	wire rst_low     = ~link.reset_in_n;
	wire dtr_active  = ~link.dtr_n;

	// Trigger and pulse qualification
	wire pon_valid   = reached(pon_cnt_q, PON_CYC) & pon_low;
	wire rst_valid   = reached(rst_cnt_q, RST_CYC) & rst_low & ~pon_low;
	wire off_ok      = link.off_cmd & ~pon_low;
	wire shut_down   = rst_valid | off_ok;

	// Sleep entry and wake decode
	wire null_rx     = link.rx_valid & (link.rx_byte == WAKE_BYTE);
	wire idle_done   = reached(idle_cnt_q, SLEEP_CYC);
	wire dtr_sleep   = cfg_dtr & ~dtr_active & idle_done;
	wire task_sleep  = cfg_idle & ~tasks_busy & idle_done;
	wire want_sleep  = (dtr_sleep | task_sleep) & ~cfg_never;
	wire dtr_wake    = cfg_dtr & dtr_active;
	wire null_wake   = cfg_idle & null_rx;
	wire wake        = dtr_wake | null_wake;

	// Idle timer held clear in never-sleep, so a new setting waits its full delay
	wire idle_reset  = dtr_wake | (cfg_idle & (tasks_busy | link.rx_valid)) | cfg_never;
	wire idle_run    = (state_q == ST_ON) & ~idle_reset;

	// Sleep command with an accepted code; code 3 is dropped
	wire cfg_write   = link.sleep_cmd & (link.sleep_cmd_arg <= SLP_NEVER);

	// State choice; shutdown wins over sleep and wake
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF: begin
				if (pon_valid) begin
					state_d = ST_ON;
				end
			end
			ST_ON: begin
				if (shut_down) begin
					state_d = ST_OFF;
				end else if (want_sleep) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (shut_down) begin
					state_d = ST_OFF;
				end else if (wake) begin
					state_d = ST_ON;
				end
			end
		endcase
	end

	// Counter next values: count while held, clear on release
	always_comb begin
		pon_cnt_d  = pon_low ? bump(pon_cnt_q) : '0;
		rst_cnt_d  = rst_low ? bump(rst_cnt_q) : '0;
		idle_cnt_d = idle_run ? bump(idle_cnt_q) : '0;
	end

	// Sleep setting next value, back to default whenever power is lost
	always_comb begin
		cfg_d = cfg_q;
		if (state_q == ST_OFF) begin
			cfg_d = SLEEP_CFG_RESET;
		end else if (cfg_write) begin
			cfg_d = link.sleep_cmd_arg;
		end
	end

	// Request pin low-time counter
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pon_cnt_q <= '0;
		end else begin
			pon_cnt_q <= pon_cnt_d;
		end
	end

	// Reset pin low-time counter
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rst_cnt_q <= '0;
		end else begin
			rst_cnt_q <= rst_cnt_d;
		end
	end

	// Idle timer ahead of sleep entry
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			idle_cnt_q <= '0;
		end else begin
			idle_cnt_q <= idle_cnt_d;
		end
	end

	// Sleep setting register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg_q <= SLEEP_CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Power state register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// IO rail indicator, up in every powered state
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rail_q <= 1'b0;
		end else begin
			rail_q <= (state_d != ST_OFF);
		end
	end

	// Sleep flag
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			asleep_q <= 1'b0;
		end else begin
			asleep_q <= (state_d == ST_SLEEP);
		end
	end

	// Powered flag for the local side
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			powered_q <= 1'b0;
		end else begin
			powered_q <= (state_d != ST_OFF);
		end
	end

	// Outputs straight from their registers
	assign link.io_rail_indicator = rail_q;
	assign link.asleep            = asleep_q;
	assign powered                = powered_q;
	assign sleep_cfg              = cfg_q;
endmodule

/* src/mps_host.sv */
// Purpose: Host end: drives request, reset, DTR and command strobes
// Assumes: User requests are one-cycle pulses; on, off and emergency accepted only when idle
// Notes:   Request pin is only pulled low or released
`timescale 1ns/1ps
module mps_host #(
	parameter int unsigned PON_CYC = mps_pkg::PON_MIN_CYC,
	parameter int unsigned RST_CYC = mps_pkg::RST_PULSE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	mps_if.host             link,
	input  wire logic       start_on,
	input  wire logic       start_off,
	input  wire logic       start_emerg,
	input  wire logic       set_sleep,
	input  wire logic [1:0] sleep_arg,
	input  wire logic       dtr_level_n,
	input  wire logic       send_byte,
	input  wire logic [7:0] byte_val,
	output logic            busy,
	output logic            rail_seen
);
	import mps_pkg::*;

	logic [CNT_W-1:0] cnt_q;
	logic             pon_q, rst_q, busy_q, off_q, slp_q, rxv_q, dtr_q, rail_q;
	logic [1:0]       arg_q;
	logic [7:0]       byte_q;

	wire idle = ~busy_q;
	wire done = (cnt_q == '0);

	// Pulse sequencing: hold request or reset low for its full time
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pon_q  <= 1'b0;
			rst_q  <= 1'b0;
			busy_q <= 1'b0;
			cnt_q  <= '0;
		end else if (idle && start_on) begin
			pon_q  <= 1'b1;
			busy_q <= 1'b1;
			cnt_q  <= CNT_W'(PON_CYC);
		end else if (idle && start_emerg) begin
			rst_q  <= 1'b1;
			busy_q <= 1'b1;
			cnt_q  <= CNT_W'(RST_CYC);
		end else if (busy_q) begin
			if (done) begin
				pon_q  <= 1'b0;
				rst_q  <= 1'b0;
				busy_q <= 1'b0;
			end else
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Command strobes, power-off only with request released
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			off_q  <= 1'b0;
			slp_q  <= 1'b0;
			arg_q  <= SLEEP_CFG_RESET;
			rxv_q  <= 1'b0;
			byte_q <= 8'h00;
			dtr_q  <= 1'b1;
			rail_q <= 1'b0;
		end else begin
			off_q  <= idle & start_off & ~pon_q;
			slp_q  <= set_sleep;
			if (set_sleep) arg_q <= sleep_arg;
			rxv_q  <= send_byte;
			if (send_byte) byte_q <= byte_val;
			dtr_q  <= dtr_level_n;
			rail_q <= link.io_rail_indicator;
		end
	end

	assign link.power_on_request_n_oe = pon_q;
	assign link.reset_in_n            = ~rst_q;
	assign link.off_cmd               = off_q;
	assign link.sleep_cmd             = slp_q;
	assign link.sleep_cmd_arg         = arg_q;
	assign link.rx_valid              = rxv_q;
	assign link.rx_byte               = byte_q;
	assign link.dtr_n                 = dtr_q;
	assign busy                       = busy_q;
	assign rail_seen                  = rail_q;
endmodule

/* testbench/mps_chk_sva.sv */
// Purpose: Assertions on the power and sleep link
// Assumes: Counts match the bench parameters
// Notes:   Helper counters hold run lengths of pin levels
`timescale 1ns/1ps
module mps_chk import mps_pkg::*; #(
	parameter int unsigned PON_CYC   = 20,
	parameter int unsigned RST_CYC   = 10,
	parameter int unsigned SLEEP_CYC = 8
) (
	input logic       ref_clk,
	input logic       reset_n,
	input logic       power_on_request_n,
	input logic       reset_in_n,
	input logic       dtr_n,
	input logic       rx_valid,
	input logic [7:0] rx_byte,
	input logic       off_cmd,
	input logic       sleep_cmd,
	input logic [1:0] sleep_cmd_arg,
	input logic       io_rail_indicator,
	input logic       asleep,
	input logic       tasks_busy
);
	logic [7:0] lo_q, rst_q, hi_q, idle_q;
	logic [1:0] cfg_q;
	function automatic logic [7:0] sat(input logic [7:0] v);
		return v + {7'h00, v != 8'hff};
	endfunction
	// Run lengths of held levels and tracked sleep setting
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			{lo_q, rst_q, hi_q, idle_q} <= 32'h0;
			cfg_q <= SLEEP_CFG_RESET;
		end else begin
			lo_q <= power_on_request_n ? 8'h00 : sat(lo_q);
			rst_q <= (reset_in_n || !power_on_request_n) ? 8'h00 : sat(rst_q);
			hi_q <= (!dtr_n || sleep_cmd || !io_rail_indicator) ? 8'h00 : sat(hi_q);
			idle_q <= (tasks_busy || rx_valid || sleep_cmd || !io_rail_indicator) ? 8'h00 : sat(idle_q);
			if (!io_rail_indicator)
				cfg_q <= SLEEP_CFG_RESET;
			else if (sleep_cmd && sleep_cmd_arg != 2'h3)
				cfg_q <= sleep_cmd_arg;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	rail_rise_a: assert property ($rose(io_rail_indicator) |-> lo_q inside {[PON_CYC-1:PON_CYC+1]})
		else $error("rail rose at wrong count");
	rail_bound_a: assert property (lo_q == PON_CYC+1 |-> io_rail_indicator)
		else $error("rail late");
	off_ignore_a: assert property (off_cmd && !power_on_request_n && io_rail_indicator |=> io_rail_indicator[*3])
		else $error("off taken while request low");
	emerg_off_a: assert property (rst_q == RST_CYC |-> ##[0:2] !io_rail_indicator)
		else $error("emergency off missed");
	dtr_awake_a: assert property ((cfg_q == 2'h0 && !dtr_n)[*3] |-> !asleep)
		else $error("asleep with line low");
	dtr_sleep_a: assert property (hi_q == SLEEP_CYC+3 && cfg_q == 2'h0 |-> asleep)
		else $error("no sleep with line high");
	dtr_wake_a: assert property ($fell(dtr_n) && cfg_q == 2'h0 && asleep |-> ##[1:2] !asleep)
		else $error("no wake on line low");
	idle_sleep_a: assert property (idle_q == SLEEP_CYC+3 && cfg_q == 2'h1 |-> asleep)
		else $error("no sleep when idle");
	null_wake_a: assert property (rx_valid && rx_byte == WAKE_BYTE && cfg_q == 2'h1 && asleep
		|-> ##[1:2] !asleep)
		else $error("no wake on null byte");
	never_sleep_a: assert property ($rose(asleep) |-> cfg_q != 2'h2 && !$past(tasks_busy) || cfg_q == 2'h0)
		else $error("sleep not allowed");
endmodule

/* testbench/module_power_sleep_control_tb_top.sv */
// Purpose: Bench for host and module ends of the power link
// Assumes: Shortened counts, 125 MHz clock
// Notes:   Second device is driven by the bench to break host rules
`timescale 1ns/1ps
module module_power_sleep_control_tb_top;
	import mps_pkg::*;
	localparam int unsigned PC = 20;
	localparam int unsigned RC = 10;
	localparam int unsigned SC = 8;
	logic       ref_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       tasks_busy = 1'b1;
	logic       dtr_level_n = 1'b0;
	logic [4:0] go = 5'h00;
	logic [1:0] sleep_arg = 2'h0;
	logic [7:0] byte_val = 8'h00;
	logic       busy, rail_seen, powered;
	logic [1:0] sleep_cfg;
	int         bad_count = 0;
	int         n_compared = 0;
	mps_if lk ();
	mps_if lk2 ();
	// State seen at the module end
	wire [7:0] st = {3'h0, lk.io_rail_indicator, lk.asleep, powered, sleep_cfg};
	// Clock
	always #4 ref_clk = ~ref_clk;
	mps_host #(.PON_CYC(PC), .RST_CYC(RC)) mps_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(lk.host), .start_on(go[0]), .start_off(go[1]), .start_emerg(go[2]),
		.set_sleep(go[3]), .sleep_arg(sleep_arg), .dtr_level_n(dtr_level_n),
		.send_byte(go[4]), .byte_val(byte_val), .busy(busy), .rail_seen(rail_seen));
	mps_device #(.PON_CYC(PC), .RST_CYC(RC), .SLEEP_CYC(SC)) mps_device_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(lk.dev), .tasks_busy(tasks_busy), .powered(powered),
		.sleep_cfg(sleep_cfg));
	mps_device #(.PON_CYC(PC), .RST_CYC(RC), .SLEEP_CYC(SC)) mps_device_x_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(lk2.dev), .tasks_busy(tasks_busy), .powered(), .sleep_cfg());
	mps_chk #(.PON_CYC(PC), .RST_CYC(RC), .SLEEP_CYC(SC)) mps_chk_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .power_on_request_n(lk.power_on_request_n),
		.reset_in_n(lk.reset_in_n), .dtr_n(lk.dtr_n), .rx_valid(lk.rx_valid),
		.rx_byte(lk.rx_byte), .off_cmd(lk.off_cmd), .sleep_cmd(lk.sleep_cmd),
		.sleep_cmd_arg(lk.sleep_cmd_arg), .io_rail_indicator(lk.io_rail_indicator),
		.asleep(lk.asleep), .tasks_busy(tasks_busy));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic run(input logic [4:0] m);
		int n;
		n = 0;
		@(posedge ref_clk) go <= m;
		@(posedge ref_clk) go <= 5'h00;
		tick(2);
		while (busy !== 1'b0 && n < 200) begin
			tick(1);
			n++;
		end
	endtask
	task automatic off2;
		@(posedge ref_clk) lk2.off_cmd <= 1'b1;
		@(posedge ref_clk) lk2.off_cmd <= 1'b0;
		tick(3);
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		tick(5000);
		bad_count++;
		stop_test;
	end
	// Main sequence
	initial begin
		{lk2.power_on_request_n_oe, lk2.reset_in_n, lk2.dtr_n, lk2.rx_valid} = 4'h6;
		{lk2.rx_byte, lk2.off_cmd, lk2.sleep_cmd, lk2.sleep_cmd_arg} = 12'h000;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		tick(1);
		check("reset", st, 8'h02);
		run(5'h01);
		check("on", st, 8'h16);
		check("released", {6'h0, lk.power_on_request_n, rail_seen}, 8'h03);
		@(posedge ref_clk) {dtr_level_n, tasks_busy} <= 2'b10;
		tick(3 * SC);
		check("never", st, 8'h16);
		run(5'h08);
		tick(2);
		check("dtr delay", st, 8'h14);
		tick(SC + 4);
		check("dtr sleep", st, 8'h1c);
		@(posedge ref_clk) dtr_level_n <= 1'b0;
		tick(3 * SC);
		check("dtr wake", st, 8'h14);
		@(posedge ref_clk) {sleep_arg, tasks_busy} <= 3'b011;
		run(5'h08);
		tick(3 * SC);
		check("busy awake", st, 8'h15);
		@(posedge ref_clk) tasks_busy <= 1'b0;
		tick(SC + 4);
		check("idle sleep", st, 8'h1d);
		@(posedge ref_clk) byte_val <= 8'h55;
		run(5'h10);
		tick(2);
		check("odd byte", st, 8'h1d);
		@(posedge ref_clk) {tasks_busy, byte_val} <= {1'b1, 8'h00};
		run(5'h10);
		tick(2);
		check("null wake", st, 8'h15);
		run(5'h04);
		check("emergency", st, 8'h02);
		run(5'h01);
		run(5'h02);
		tick(3);
		check("orderly off", st, 8'h02);
		@(posedge ref_clk) lk2.power_on_request_n_oe <= 1'b1;
		tick(PC - 5);
		@(posedge ref_clk) lk2.power_on_request_n_oe <= 1'b0;
		tick(PC + 4);
		check("short", {7'h0, lk2.io_rail_indicator}, 8'h00);
		@(posedge ref_clk) lk2.power_on_request_n_oe <= 1'b1;
		tick(PC + 4);
		off2;
		check("off held", {7'h0, lk2.io_rail_indicator}, 8'h01);
		@(posedge ref_clk) lk2.power_on_request_n_oe <= 1'b0;
		off2;
		check("off taken", {7'h0, lk2.io_rail_indicator}, 8'h00);
		stop_test;
	end
endmodule
